/* src/mc_codec.sv */
// manchester encoder, decoder, collision translator and loopback
// assumes one 40 MHz clock; all pins but rst are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none

// Function
// (RQ1) send clock is the 20 MHz oscillator rate halved to 10 MHz; here the 40 MHz clk_sys is divided by four
// (RQ2) encoding starts when frame enable rises, continues while it stays high
// (RQ3) controller drives enable and data synchronous to the send clock rising edge
// (RQ4) frame ends when enable is sampled low; output returns to idle
// (RQ5) final transition of a frame is always positive-going
// (RQ6) idle select low: positive leg high; high: both legs equal
// (RQ7) receive squelch ignores very short negative pulses, accepts long excursions
// (RQ8) carrier present asserts once receive input passes squelch
// (RQ9) recovered data and clock become valid after phase lock, about 6 bits
// (RQ10) end of frame is seen when mid-cell transitions stop
// (RQ11) carrier present drops within about one and a half bit times
// (RQ12) recovered clock runs five more bits after carrier drops, then stays low
// (RQ13) decoder tolerates edge timing deviation of about 18 ns
// (RQ14) collision output high while a 10 MHz collision signal is present
// (RQ15) collision output drops within 350 ns after the signal stops
// (RQ16) collision input has its own squelch against short pulses
// (RQ17) controller backs off its transmission on collision
// (RQ18) loopback feeds encoder output into the decoder instead of the line
// (RQ19) in loopback the line driver idles, receive and collision inputs off
// (RQ20) controller captures recovered data on recovered clock rising edge
// (RQ21) send clock runs continuously, frame or not
// (RQ22) one rises at mid-cell, zero falls at mid-cell
// (RQ23) encoder updates once per half cell, aligned to the send clock
module mc_codec (
   input wire logic clk_sys, // 40 MHz system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic frame_send_enable, // frame gate from controller
   input wire logic send_data, // serial nrz data from controller
   input wire logic idle_mode_select, // high: zero differential idle
   input wire logic loopback_select, // high: internal loopback
   input wire logic rx_in_p, // receive pair, positive leg
   input wire logic rx_in_n, // receive pair, negative leg
   input wire logic col_in_p, // collision pair, positive leg
   input wire logic col_in_n, // collision pair, negative leg
   output logic send_clock_out, // 10 MHz send clock to controller
   output logic tx_out_p, // line driver, positive leg
   output logic tx_out_n, // line driver, negative leg
   output logic carrier_present, // receive carrier present
   output logic recovered_data, // nrz data from the phase lock
   output logic recovered_clock, // recovered bit clock
   output logic collision_detect // collision indication
);

   function automatic logic [4:0] sq_step(input logic [4:0] cnt, input logic neg);
      if (!neg)
         return 5'h00;
      return (cnt == mc_pkg::SQ_CYC) ? cnt : cnt + 5'h01;
   endfunction : sq_step

   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_reg <= mc_pkg::SYNC_RST;
         sync2_reg <= mc_pkg::SYNC_RST;
      end else begin
         sync1_reg <= {frame_send_enable, send_data, idle_mode_select, loopback_select,
                       rx_in_p, rx_in_n, col_in_p, col_in_n};
         sync2_reg <= sync1_reg;
      end
   end
   wire fse_s = sync2_reg[7];
   wire txd_s = sync2_reg[6];
   wire sel_s = sync2_reg[5];
   wire lbk_s = sync2_reg[4];
   wire rxp_s = sync2_reg[3];
   wire rxn_s = sync2_reg[2];
   wire colp_s = sync2_reg[1];
   wire coln_s = sync2_reg[0];

   // encoder
   logic [1:0] tx_ph_reg;
   logic sco_reg;
   mc_pkg::mc_tx_state_t tx_state_reg, tx_state_next;
   logic tx_bit_reg, tx_bit_next;
   logic tx_lvl_reg, tx_lvl_next;
   logic tx_p_reg, tx_n_reg;

   wire [1:0] tx_ph_next = tx_ph_reg + 2'h1;
   wire sco_next = tx_ph_next <= mc_pkg::TX_CLK_HI_PH;
   // synced inputs lag the pins by two cycles: phase 1 sees the pin at the edge
   wire tx_tick_s = tx_ph_reg == mc_pkg::TX_SAMPLE_PH; // RQ3
   wire tx_tick_m = tx_ph_reg == mc_pkg::TX_MID_PH;
   wire tx_drive = tx_state_reg != mc_pkg::TX_IDLE;
   wire tx_line_drive = tx_drive && !lbk_s; // RQ19
   wire tx_p_next = tx_line_drive ? tx_lvl_reg : !sel_s; // RQ6
   wire tx_n_next = tx_line_drive && !tx_lvl_reg;

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_bit_next = tx_bit_reg;
      tx_lvl_next = tx_lvl_reg;
      case (tx_state_reg)
         mc_pkg::TX_IDLE: begin
            if (tx_tick_s && fse_s) begin
               tx_state_next = mc_pkg::TX_SEND; // RQ2
               tx_bit_next = txd_s;
               tx_lvl_next = !txd_s; // RQ22
            end
         end
         mc_pkg::TX_SEND: begin
            if (tx_tick_s && fse_s) begin
               tx_bit_next = txd_s; // RQ2
               tx_lvl_next = !txd_s; // RQ22
            end else if (tx_tick_s) begin
               tx_state_next = mc_pkg::TX_TAIL; // RQ4
               tx_lvl_next = 1'b1; // RQ5
            end else if (tx_tick_m) begin
               tx_lvl_next = tx_bit_reg; // RQ22 RQ23
            end
         end
         mc_pkg::TX_TAIL: begin
            if (tx_tick_s)
               tx_state_next = mc_pkg::TX_IDLE; // RQ4
         end
         default: tx_state_next = mc_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_ph_reg <= mc_pkg::TX_PH_RST; // low phase, so the first high period is whole
         sco_reg <= 1'b0;
         tx_state_reg <= mc_pkg::TX_IDLE;
         tx_bit_reg <= 1'b0;
         tx_lvl_reg <= 1'b1;
         tx_p_reg <= 1'b1;
         tx_n_reg <= 1'b0;
      end else begin
         tx_ph_reg <= tx_ph_next;
         sco_reg <= sco_next; // RQ1 RQ21
         tx_state_reg <= tx_state_next;
         tx_bit_reg <= tx_bit_next;
         tx_lvl_reg <= tx_lvl_next;
         tx_p_reg <= tx_p_next;
         tx_n_reg <= tx_n_next;
      end
   end

   // decoder
   mc_pkg::mc_rx_state_t rx_state_reg, rx_state_next;
   logic [4:0] sq_cnt_reg, mid_cnt_reg, mid_cnt_next;
   logic [4:0] lock_cnt_reg, lock_cnt_next, tail_cnt_reg, tail_cnt_next;
   logic dec_prev_reg;
   logic [1:0] rc_ph_reg;
   logic crs_reg, rxd_reg, rxc_reg;

   // loopback takes the encoder level; line receive path is ignored
   wire dec_lvl = lbk_s ? tx_lvl_reg : rxp_s; // RQ18 RQ19
   wire dec_neg = lbk_s ? !tx_lvl_reg : (rxn_s && !rxp_s);
   wire [4:0] sq_cnt_next = sq_step(sq_cnt_reg, dec_neg); // RQ7
   wire sq_ok = dec_neg && (sq_cnt_reg >= mc_pkg::SQ_CYC - 5'h01); // RQ7
   wire rx_active = rx_state_reg == mc_pkg::RX_ACQ || rx_state_reg == mc_pkg::RX_LOCK;
   wire dec_edge = dec_lvl != dec_prev_reg;
   // boundary edges fall inside the blanking window and are skipped
   // counter reads spacing minus one: a mid edge one cycle early is still taken
   wire mid_edge = rx_active && dec_edge && mid_cnt_reg >= mc_pkg::MID_MIN - 5'h01; // RQ13
   wire eof = rx_active && !mid_edge && mid_cnt_reg == mc_pkg::EOF_CYC - 5'h01; // RQ10
   wire [4:0] mid_inc = (mid_cnt_reg == mc_pkg::EOF_CYC) ? mid_cnt_reg : mid_cnt_reg + 5'h01;
   wire [1:0] rc_ph_next = mid_edge ? 2'h0 : rc_ph_reg + 2'h1;
   wire rclk_on = rx_state_next == mc_pkg::RX_LOCK || rx_state_next == mc_pkg::RX_TAIL;
   wire rxc_next = rclk_on && rc_ph_next >= mc_pkg::RC_RISE_PH; // RQ9 RQ12 RQ20
   wire rxd_next = mid_edge ? dec_lvl : rxd_reg;
   wire crs_next = rx_state_next == mc_pkg::RX_ACQ || rx_state_next == mc_pkg::RX_LOCK;

   always_comb begin
      rx_state_next = rx_state_reg;
      mid_cnt_next = mid_inc;
      lock_cnt_next = lock_cnt_reg;
      tail_cnt_next = tail_cnt_reg;
      case (rx_state_reg)
         mc_pkg::RX_IDLE: begin
            if (sq_ok) begin
               rx_state_next = mc_pkg::RX_ACQ; // RQ8
               mid_cnt_next = mc_pkg::MID_MIN;
               lock_cnt_next = 5'h00;
            end
         end
         mc_pkg::RX_ACQ: begin
            if (mid_edge) begin
               mid_cnt_next = 5'h00;
               lock_cnt_next = lock_cnt_reg + 5'h01;
               if (lock_cnt_reg == mc_pkg::LOCK_BITS - 5'h01)
                  rx_state_next = mc_pkg::RX_LOCK; // RQ9
            end else if (eof) begin
               rx_state_next = mc_pkg::RX_IDLE; // RQ11
            end
         end
         mc_pkg::RX_LOCK: begin
            if (mid_edge) begin
               mid_cnt_next = 5'h00;
            end else if (eof) begin
               rx_state_next = mc_pkg::RX_TAIL; // RQ10 RQ11
               tail_cnt_next = 5'h00;
            end
         end
         mc_pkg::RX_TAIL: begin
            if (sq_ok) begin
               rx_state_next = mc_pkg::RX_ACQ; // RQ8
               mid_cnt_next = mc_pkg::MID_MIN;
               lock_cnt_next = 5'h00;
            end else if (tail_cnt_reg == mc_pkg::TAIL_CYC - 5'h01) begin
               rx_state_next = mc_pkg::RX_IDLE; // RQ12
            end else begin
               tail_cnt_next = tail_cnt_reg + 5'h01;
            end
         end
         default: rx_state_next = mc_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_state_reg <= mc_pkg::RX_IDLE;
         sq_cnt_reg <= 5'h00;
         mid_cnt_reg <= 5'h00;
         lock_cnt_reg <= 5'h00;
         tail_cnt_reg <= 5'h00;
         dec_prev_reg <= 1'b1;
         rc_ph_reg <= 2'h0;
         crs_reg <= 1'b0;
         rxd_reg <= 1'b0;
         rxc_reg <= 1'b0;
      end else begin
         rx_state_reg <= rx_state_next;
         sq_cnt_reg <= sq_cnt_next;
         mid_cnt_reg <= mid_cnt_next;
         lock_cnt_reg <= lock_cnt_next;
         tail_cnt_reg <= tail_cnt_next;
         dec_prev_reg <= dec_lvl;
         rc_ph_reg <= rc_ph_next;
         crs_reg <= crs_next; // RQ8 RQ11
         rxd_reg <= rxd_next;
         rxc_reg <= rxc_next;
      end
   end

   // collision translator
   logic [4:0] csq_cnt_reg, col_hold_reg;
   logic col_reg;
   wire cneg = !lbk_s && coln_s && !colp_s; // RQ19
   wire [4:0] csq_cnt_next = sq_step(csq_cnt_reg, cneg); // RQ16
   wire col_q = cneg && (csq_cnt_reg >= mc_pkg::SQ_CYC - 5'h01); // RQ16
   // hold bridges the gaps of a 10 MHz burst, short enough for the drop bound
   wire [4:0] col_hold_next = lbk_s ? 5'h00 :
                              col_q ? mc_pkg::COL_HOLD : // RQ14
                              (col_hold_reg != 5'h00) ? col_hold_reg - 5'h01 : 5'h00; // RQ15
   wire col_next = col_hold_next != 5'h00;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         csq_cnt_reg <= 5'h00;
         col_hold_reg <= 5'h00;
         col_reg <= 1'b0;
      end else begin
         csq_cnt_reg <= csq_cnt_next;
         col_hold_reg <= col_hold_next;
         col_reg <= col_next; // RQ14 RQ15
      end
   end

   assign send_clock_out = sco_reg;
   assign tx_out_p = tx_p_reg;
   assign tx_out_n = tx_n_reg;
   assign carrier_present = crs_reg;
   assign recovered_data = rxd_reg;
   assign recovered_clock = rxc_reg;
   assign collision_detect = col_reg;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [4:0] col_quiet_reg;
   always_ff @(posedge clk_sys) begin
      if (rst)
         col_quiet_reg <= 5'h00;
      else if (col_q)
         col_quiet_reg <= 5'h00;
      else if (col_quiet_reg != 5'h1f)
         col_quiet_reg <= col_quiet_reg + 5'h01;
   end

   chk_txclk_period: assert property ( // RQ1
      $rose(sco_reg) |=> sco_reg ##1 !sco_reg ##1 !sco_reg ##1 sco_reg)
      else $error("send clock is not a 10 MHz square wave");
   chk_tx_start: assert property ( // RQ2
      tx_state_reg == mc_pkg::TX_IDLE && tx_tick_s && fse_s
      |=> tx_state_reg == mc_pkg::TX_SEND && tx_lvl_reg == !$past(txd_s))
      else $error("frame did not start on enable");
   chk_tx_end: assert property ( // RQ4
      tx_state_reg == mc_pkg::TX_SEND && tx_tick_s && !fse_s
      |=> tx_state_reg == mc_pkg::TX_TAIL ##4 tx_state_reg == mc_pkg::TX_IDLE)
      else $error("frame did not end one bit after enable low");
   chk_final_rise: assert property ( // RQ5
      tx_state_reg == mc_pkg::TX_TAIL |-> tx_lvl_reg ##1 tx_lvl_reg)
      else $error("frame did not end on a high level");
   chk_mid_cell: assert property ( // RQ22
      tx_state_reg == mc_pkg::TX_SEND && tx_tick_m
      |=> tx_lvl_reg == $past(tx_bit_reg) && tx_lvl_reg != $past(tx_lvl_reg))
      else $error("missing mid-cell transition");
   chk_idle_mode: assert property ( // RQ6
      !tx_line_drive |=> tx_out_p == !$past(sel_s) && !tx_out_n)
      else $error("idle level does not follow select");
   chk_lbk_quiet: assert property ( // RQ19
      lbk_s |=> !tx_out_n && !collision_detect)
      else $error("line or collision active in loopback");
   chk_crs_on: assert property ( // RQ8
      rx_state_reg == mc_pkg::RX_IDLE && sq_ok |=> carrier_present)
      else $error("carrier not raised after squelch");
   chk_crs_off: assert property ( // RQ11
      eof |=> !carrier_present)
      else $error("carrier not dropped at end of frame");
   chk_rxc_lock: assert property ( // RQ9
      recovered_clock |-> rx_state_reg == mc_pkg::RX_LOCK || rx_state_reg == mc_pkg::RX_TAIL)
      else $error("recovered clock without lock");
   chk_rxc_tail: assert property ( // RQ12
      $fell(carrier_present) && rx_state_reg == mc_pkg::RX_TAIL
      |-> ##[17:20] recovered_clock ##[1:4] rx_state_reg != mc_pkg::RX_TAIL)
      else $error("recovered clock tail length wrong");
   chk_col_on: assert property ( // RQ14
      col_q |=> collision_detect)
      else $error("collision not indicated");
   chk_col_off: assert property ( // RQ15
      col_quiet_reg > mc_pkg::COL_HOLD |-> !collision_detect)
      else $error("collision held too long");

   cov_frame_sent: cover property (
      tx_state_reg == mc_pkg::TX_SEND ##1 tx_state_reg == mc_pkg::TX_TAIL);
   cov_rx_lock: cover property (rx_state_reg == mc_pkg::RX_LOCK && recovered_clock);
   cov_rx_tail: cover property (rx_state_reg == mc_pkg::RX_TAIL ##1 rx_state_reg == mc_pkg::RX_IDLE);
   cov_collision: cover property ($fell(collision_detect));
   cov_loop_lock: cover property (lbk_s && rx_state_reg == mc_pkg::RX_LOCK);

endmodule : mc_codec

`default_nettype wire

/* src/mc_pkg.sv */
// constants and types for the 10 Mbit/s manchester line codec
// assumes clk_sys at 40 MHz; every time below is turned into cycles of it
package mc_pkg;
   localparam int CLK_NS = 25;
   localparam int BIT_NS = 100;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   // send clock phase: high in phases 0 and 1, rising into phase 0
   localparam logic [1:0] TX_SAMPLE_PH = 2'h1;
   localparam logic [1:0] TX_MID_PH = 2'h3;
   localparam logic [1:0] TX_CLK_HI_PH = 2'h1;
   localparam logic [1:0] RC_RISE_PH = 2'h2;
   localparam logic [1:0] TX_PH_RST = 2'h2;
   // squelch: shorter pulses ignored, longer ones always valid
   localparam int SQ_IGNORE_NS = 5;
   localparam int SQ_VALID_NS = 30;
   localparam int SQ_IGN_CYC = (SQ_IGNORE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SQ_VAL_CYC = SQ_VALID_NS / CLK_NS;
   localparam int SQ_MAX = (SQ_IGN_CYC > SQ_VAL_CYC) ? SQ_IGN_CYC : SQ_VAL_CYC;
   localparam logic [4:0] SQ_CYC = 5'(SQ_MAX < 1 ? 1 : SQ_MAX);
   // edge timing tolerance of the phase lock
   localparam int JIT_NS = 18;
   localparam int JIT_CYC = (JIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [4:0] MID_MIN = 5'(BIT_CYC - JIT_CYC);
   localparam logic [4:0] EOF_CYC = 5'(BIT_CYC + BIT_CYC / 2);
   localparam logic [4:0] LOCK_BITS = 5'h06;
   localparam int TAIL_BITS = 5;
   localparam logic [4:0] TAIL_CYC = 5'(TAIL_BITS * BIT_CYC);
   localparam int COL_DROP_NS = 350;
   localparam int COL_LAT_CYC = 4;
   localparam logic [4:0] COL_HOLD = 5'(COL_DROP_NS / CLK_NS - COL_LAT_CYC);
   localparam logic [7:0] SYNC_RST = 8'h00;

   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_TAIL} mc_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_ACQ, RX_LOCK, RX_TAIL} mc_rx_state_t;
endpackage : mc_pkg

/* testbench/mc_nic_model.sv */
// controller model: sends nrz frames on the send clock, captures recovered data
// assumes the codec samples enable and data near each send clock rising edge
`timescale 1ns/1ps
`default_nettype none
module mc_nic_model (
   input wire logic clk_sys, // codec clock
   input wire logic send_clock_out, // send clock from codec
   input wire logic collision_detect, // collision from codec
   input wire logic recovered_clock, // recovered clock
   input wire logic recovered_data, // recovered data
   input wire logic go, // start a frame
   input wire logic [63:0] bits, // frame bits, msb first
   input wire logic [6:0] len, // bit count
   output logic frame_send_enable, // frame gate
   output logic send_data, // nrz data
   output logic busy, // frame in progress
   output logic aborted, // last frame backed off
   output logic [63:0] rx_shift // captured bits, newest in bit 0
);
   logic sc_prev = 1'b0;
   int idx = 0;
   initial begin
      frame_send_enable = 1'b0;
      send_data = 1'b0;
      busy = 1'b0;
      aborted = 1'b0;
      rx_shift = '0;
   end
   // drive just after the send clock rises, hold for a whole period
   always @(negedge clk_sys) begin
      sc_prev <= send_clock_out;
      if (!busy && go) begin
         busy <= 1'b1;
         aborted <= 1'b0;
         idx <= 0;
      end else if (busy && send_clock_out && !sc_prev) begin
         if (collision_detect) begin
            frame_send_enable <= 1'b0;
            aborted <= 1'b1;
            busy <= 1'b0;
         end else if (idx < len) begin
            frame_send_enable <= 1'b1;
            send_data <= bits[len - 1 - idx];
            idx <= idx + 1;
         end else begin
            frame_send_enable <= 1'b0;
            send_data <= ~send_data; // data is not held once the gate drops
            busy <= 1'b0;
         end
      end
   end
   always @(posedge recovered_clock) begin
      rx_shift <= {rx_shift[62:0], recovered_data};
   end
endmodule : mc_nic_model
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the manchester codec with a controller model
// assumes clk_sys at 40 MHz; line and collision pairs are driven here
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic idle_mode_select = 1'b0;
   logic loopback_select = 1'b0;
   logic rx_in_p = 1'b0, rx_in_n = 1'b0, col_in_p = 1'b0, col_in_n = 1'b0;
   logic frame_send_enable, send_data, send_clock_out, tx_out_p, tx_out_n;
   logic carrier_present, recovered_data, recovered_clock, collision_detect;
   logic go = 1'b0;
   logic busy, aborted;
   logic [63:0] bits = '0;
   logic [63:0] rx_shift;
   logic [6:0] len = '0;
   int num_errors = 0;
   int comparisons = 0;
   mc_codec dut (.clk_sys, .rst, .frame_send_enable, .send_data, .idle_mode_select,
      .loopback_select, .rx_in_p, .rx_in_n, .col_in_p, .col_in_n, .send_clock_out,
      .tx_out_p, .tx_out_n, .carrier_present, .recovered_data, .recovered_clock,
      .collision_detect);
   mc_nic_model nic (.clk_sys, .send_clock_out, .collision_detect, .recovered_clock,
      .recovered_data, .go, .bits, .len, .frame_send_enable, .send_data, .busy,
      .aborted, .rx_shift);
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic stop_test;
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic col_tick(input int k);
      col_in_n = (k % 4) < 2;
      col_in_p = (k % 4) >= 2;
   endtask : col_tick
   function automatic logic has(input logic [63:0] v, input logic [15:0] p);
      has = 1'b0;
      for (int i = 0; i < 49; i++) if (v[i +: 16] === p) has = 1'b1;
   endfunction : has
   // go is nonblocking so the model, also on the falling edge, sees it a cycle later
   task automatic send(input logic [63:0] b, input logic [6:0] n);
      bits = b;
      len = n;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
   endtask : send
   task automatic t_clock;
      int i;
      for (i = 0; i < 4 && send_clock_out !== 1'b0; i++) cyc(1);
      for (i = 0; i < 4 && send_clock_out !== 1'b1; i++) cyc(1);
      for (i = 0; i < 16; i++) begin
         `CHECK("send_clock_out", (i % 4) < 2, send_clock_out)
         cyc(1);
      end
   endtask : t_clock
   task automatic t_idle(input logic sel);
      idle_mode_select = sel;
      cyc(4);
      `CHECK("idle pair", {~sel, 1'b0}, {tx_out_p, tx_out_n})
   endtask : t_idle
   task automatic t_send(input logic [15:0] b);
      logic cp[160];
      logic cn[160];
      int i;
      int s;
      idle_mode_select = 1'b1;
      cyc(4);
      send({48'h0, b}, 7'd16);
      for (i = 0; i < 160; i++) begin
         cp[i] = tx_out_p;
         cn[i] = tx_out_n;
         cyc(1);
      end
      s = 0;
      while (s < 80 && cp[s] === cn[s]) s++;
      for (i = 0; i < 34; i++) begin
         `CHECK("tx half", i > 31 ? 1'b1 : b[15 - i / 2] ^ !(i % 2), cp[s + 2 * i])
         `CHECK("tx hold", cp[s + 2 * i], cp[s + 2 * i + 1])
         `CHECK("tx pair", ~cp[s + 2 * i], cn[s + 2 * i])
      end
      `CHECK("tx end idle", 2'b00, {cp[s + 68], cn[s + 68]})
   endtask : t_send
   task automatic t_recv;
      logic [31:0] f = {16'hAAAA, 16'hD5A7};
      logic pv;
      int i;
      int c;
      int r;
      int h;
      c = -1;
      for (i = 0; i < 128; i++) begin
         h = (i / 4 == 19) ? 3 : (i / 4 == 25) ? 1 : 2;
         rx_in_p = f[31 - i / 4] ^ ((i % 4) < h);
         rx_in_n = ~rx_in_p;
         if (c < 0 && carrier_present === 1'b1) c = i;
         cyc(1);
      end
      `CHECK("carrier on", 1'b1, c >= 0 && c <= 6)
      `CHECK("carrier held", 1'b1, carrier_present)
      rx_in_p = 1'b0;
      rx_in_n = 1'b0;
      for (i = 0; i < 12 && carrier_present !== 1'b0; i++) cyc(1);
      `CHECK("carrier off", 1'b1, i <= 8)
      r = 0;
      pv = recovered_clock;
      for (i = 0; i < 28; i++) begin
         cyc(1);
         if (recovered_clock === 1'b1 && pv === 1'b0) r++;
         pv = recovered_clock;
      end
      `CHECK("rxc tail rises", 1'b1, r >= 4 && r <= 6)
      r = 0;
      for (i = 0; i < 20; i++) begin
         cyc(1);
         if (recovered_clock !== 1'b0) r++;
      end
      `CHECK("rxc parked", 0, r)
      `CHECK("rx data", 1'b1, has(rx_shift, 16'hD5A7))
   endtask : t_recv
   task automatic t_loop;
      int i;
      loopback_select = 1'b1;
      idle_mode_select = 1'b0;
      cyc(4);
      send({32'h0, 16'hAAAA, 16'hD5A6}, 7'd32);
      t_clock();
      for (i = 0; i < 160; i++) begin
         col_tick(i);
         rx_in_n = 1'b1;
         `CHECK("loop line", 2'b10, {tx_out_p, tx_out_n})
         `CHECK("loop col", 1'b0, collision_detect)
         cyc(1);
      end
      col_in_n = 1'b0;
      rx_in_n = 1'b0;
      for (i = 0; i < 40 && busy !== 1'b0; i++) cyc(1);
      `CHECK("loop done", 1'b0, busy)
      `CHECK("loop data", 1'b1, has(rx_shift, 16'hD5A6))
      loopback_select = 1'b0;
      cyc(8);
   endtask : t_loop
   task automatic t_col;
      int i;
      int on;
      send({64{1'b1}}, 7'd64);
      cyc(20);
      on = -1;
      for (i = 0; i < 40; i++) begin
         col_tick(i);
         if (on < 0 && collision_detect === 1'b1) on = i;
         if (on >= 0 && collision_detect !== 1'b1) on = 99;
         cyc(1);
      end
      `CHECK("col on", 1'b1, on >= 0 && on <= 6)
      col_in_p = 1'b0;
      for (i = 0; i < 20 && collision_detect !== 1'b0; i++) cyc(1);
      `CHECK("col off", 1'b1, i <= 12)
      `CHECK("backoff", 1'b1, aborted)
      cyc(12);
      `CHECK("abort idle", 2'b10, {tx_out_p, tx_out_n})
   endtask : t_col
   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(4);
      t_clock();
      t_idle(1'b0);
      t_idle(1'b1);
      t_send(16'hA5C3);
      t_send(16'h5A3C);
      t_recv();
      t_loop();
      t_idle(1'b0);
      t_col();
      stop_test();
   end
endmodule : tb
`default_nettype wire
